// ==== gpib_msg_pkg.sv ====
// What this block does
// - address bytes act at once, never queued
// - own addresses set listener/talker; unlisten/untalk drop
// - universal commands act at once; only clear queued
// - attention high decodes commands, low passes data
// - interface clear idles only the bus functions
// - own listen address with remote enable goes remote
// - remote enable low: local, lockout removed
// - device clear flushes buffer, queues clear char first
// - device clear waits for running measurement
// - lockout disables the front panel local button
// - serial poll enabled talker sends status byte
// - serial poll disable resumes output buffer data
// - addressed commands only while addressed to listen
// - trigger queues one char and ends string
// - queued trigger executes in turn, starts measurement
// - go-to-local switches local, queues nothing
// - selected clear acts as device clear when listening
// - talk-only switch sampled at power-up and clear
// - talk-only set means permanent talker
// - device clear and power-up zero the request mask
// - new command string clears serial poll status
package gpib_msg_pkg;
   // bus message codes, seven bits significant
   localparam logic [6:0] LISTEN_GROUP = 7'h20;
   localparam logic [6:0] TALK_GROUP = 7'h40;
   localparam logic [6:0] MSG_UNLISTEN = 7'h3F;
   localparam logic [6:0] MSG_UNTALK = 7'h5F;
   localparam logic [6:0] MSG_GO_LOCAL = 7'h01;
   localparam logic [6:0] MSG_SEL_CLEAR = 7'h04;
   localparam logic [6:0] MSG_TRIGGER = 7'h08;
   localparam logic [6:0] MSG_LOCKOUT = 7'h11;
   localparam logic [6:0] MSG_DEV_CLEAR = 7'h14;
   localparam logic [6:0] MSG_POLL_ON = 7'h18;
   localparam logic [6:0] MSG_POLL_OFF = 7'h19;
   localparam logic [4:0] NO_ADDRESS = 5'h1F;
   // characters placed in the input buffer
   localparam logic [7:0] CLEAR_CHAR = 8'h2A;
   localparam logic [7:0] TRIGGER_CHAR = 8'h3F;
   localparam logic [7:0] STRING_END_CHAR = 8'h0A;
   // register byte offsets
   localparam logic [3:0] CTRL_OFFSET = 4'h0;
   localparam logic [3:0] MASK_OFFSET = 4'h4;
   localparam logic [3:0] STATE_OFFSET = 4'h8;
   localparam logic [3:0] POLL_OFFSET = 4'hC;
   // reset values and response codes
   localparam logic [4:0] ADDR_RESET = 5'h04;
   localparam logic [5:0] MASK_RESET = 6'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // cycles counted after reset before the talk-only strap is trusted
   localparam logic [1:0] STRAP_WAIT = 2'h3;

   typedef enum logic [1:0] {KIND_DATA, KIND_TRIG, KIND_CLEAR} cmd_kind_type;

   typedef struct packed {
      logic valid;
      cmd_kind_type kind;
      logic [7:0] data;
   } cmd_out_type;

   typedef struct packed {
      logic remote;
      logic lockout;
      logic listener;
      logic talker;
      logic spoll;
      logic talkOnly;
      logic clearPending;
      logic rqs;
   } state_type;
endpackage

// ==== gpib_interface_message_handler.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpib_interface_message_handler (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [31:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic [7:0] busData,
   input wire logic davPin,
   input wire logic atnPin,
   input wire logic ifcPin,
   input wire logic renPin,
   input wire logic localBtn,
   input wire logic talkOnlySw,
   input wire logic measBusy,
   input wire logic execTrig,
   input wire logic [7:0] outBufByte,
   input wire logic [5:0] statusSet,
   output gpib_msg_pkg::cmd_out_type cmdOut,
   output logic bufFlush,
   output logic measStart,
   output logic [7:0] talkByte,
   output gpib_msg_pkg::state_type state
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: every bus pin passes two flops
   // strobe and data share the same stages, so a byte settles together with its strobe
   logic [13:0] pinMeta_q;
   logic [13:0] pinSync_q;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pinMeta_q <= '0;
         pinSync_q <= '0;
      end else begin
         pinMeta_q <= {davPin, atnPin, ifcPin, renPin, localBtn, talkOnlySw, busData};
         pinSync_q <= pinMeta_q;
      end
   end

   logic davS, atnS, ifcS, renS, btnS, strapS;
   logic [6:0] msg;
   logic [7:0] dataS;
   assign {davS, atnS, ifcS, renS, btnS, strapS, dataS} = pinSync_q;
   assign msg = dataS[6:0];

   // edge history, read only from the second sync stage
   logic davPrev_q, ifcPrev_q, btnPrev_q;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         davPrev_q <= 1'b0;
         ifcPrev_q <= 1'b0;
         btnPrev_q <= 1'b0;
      end else begin
         davPrev_q <= davS;
         ifcPrev_q <= ifcS;
         btnPrev_q <= btnS;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // message decode
   logic [4:0] myAddr_q;
   logic [5:0] srqMask_q;
   logic remote_q, lockout_q, listener_q, talker_q, spoll_q, talkOnly_q;
   logic clearPend_q, strOpen_q, rqs_q;
   logic [5:0] pollBits_q;

   logic byteEv, cmdEv, dataEv, btnEdge, ifcRise;
   logic isMla, isMta, isUnl, isUnt, otherTalk;
   logic isGet, isGtl, isSdc, isDcl, isLlo, isSpe, isSpd;
   logic [7:0] pollByte;

   // ignore bytes while interface clear holds the bus idle
   assign byteEv = davS && !davPrev_q && !ifcS;
   assign cmdEv = byteEv && atnS;
   assign dataEv = byteEv && !atnS && listener_q;
   assign btnEdge = btnS && !btnPrev_q;
   assign ifcRise = ifcS && !ifcPrev_q;

   assign isMla = (msg[6:5] == gpib_msg_pkg::LISTEN_GROUP[6:5]) && (msg[4:0] == myAddr_q)
      && (myAddr_q != gpib_msg_pkg::NO_ADDRESS);
   assign isMta = (msg[6:5] == gpib_msg_pkg::TALK_GROUP[6:5]) && (msg[4:0] == myAddr_q)
      && (myAddr_q != gpib_msg_pkg::NO_ADDRESS);
   assign isUnl = (msg == gpib_msg_pkg::MSG_UNLISTEN);
   assign isUnt = (msg == gpib_msg_pkg::MSG_UNTALK);
   assign otherTalk = (msg[6:5] == gpib_msg_pkg::TALK_GROUP[6:5]) && !isMta && !isUnt;
   // addressed commands count only while addressed to listen
   assign isGet = (msg == gpib_msg_pkg::MSG_TRIGGER) && listener_q;
   assign isGtl = (msg == gpib_msg_pkg::MSG_GO_LOCAL) && listener_q;
   assign isSdc = (msg == gpib_msg_pkg::MSG_SEL_CLEAR) && listener_q;
   assign isDcl = (msg == gpib_msg_pkg::MSG_DEV_CLEAR);
   assign isLlo = (msg == gpib_msg_pkg::MSG_LOCKOUT);
   assign isSpe = (msg == gpib_msg_pkg::MSG_POLL_ON);
   assign isSpd = (msg == gpib_msg_pkg::MSG_POLL_OFF);

   // poll byte: bit 6 request, bit 1 never used, bit 7 zero
   assign pollByte = {1'b0, rqs_q, pollBits_q[5:2], 1'b0, pollBits_q[0]};

   ////////////////////////////////////////////////////////////////////////////
   // talker / listener / serial poll state, acted on at once
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         listener_q <= 1'b0;
         talker_q <= 1'b0;
         spoll_q <= 1'b0;
      end else if (ifcS) begin
         // interface functions only; remote and queue stay put
         listener_q <= 1'b0;
         talker_q <= 1'b0;
         spoll_q <= 1'b0;
      end else if (cmdEv) begin
         if (isMla) listener_q <= 1'b1;
         if (isUnl) listener_q <= 1'b0;
         if (isMta) talker_q <= 1'b1;
         if (isUnt || otherTalk) talker_q <= 1'b0;
         if (isSpe) spoll_q <= 1'b1;
         if (isSpd) spoll_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // remote / local and lockout
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         remote_q <= 1'b0;
         lockout_q <= 1'b0;
      end else if (!renS) begin
         remote_q <= 1'b0;
         lockout_q <= 1'b0;
      end else begin
         if (cmdEv && isMla) remote_q <= 1'b1;
         if (cmdEv && isLlo) lockout_q <= 1'b1;
         if (cmdEv && isGtl) remote_q <= 1'b0;
         // a locked-out panel button has no effect
         if (btnEdge && !lockout_q) remote_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // talk-only strap: sampled once the synchroniser holds real data, then on clear
   logic [1:0] strapCnt_q;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         strapCnt_q <= 2'h0;
         talkOnly_q <= 1'b0;
      end else if (strapCnt_q != gpib_msg_pkg::STRAP_WAIT) begin
         strapCnt_q <= strapCnt_q + 2'h1;
         if (strapCnt_q == gpib_msg_pkg::STRAP_WAIT - 2'h1) talkOnly_q <= strapS;
      end else if (ifcRise) begin
         talkOnly_q <= strapS;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // input buffer feed: data, trigger char, deferred clear
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cmdOut <= '0;
         bufFlush <= 1'b0;
         clearPend_q <= 1'b0;
         strOpen_q <= 1'b0;
      end else begin
         cmdOut.valid <= 1'b0;
         bufFlush <= 1'b0;
         if (dataEv) begin
            cmdOut.valid <= 1'b1;
            cmdOut.kind <= gpib_msg_pkg::KIND_DATA;
            cmdOut.data <= dataS;
            strOpen_q <= (dataS != gpib_msg_pkg::STRING_END_CHAR);
         end else if (cmdEv && isGet) begin
            // exactly one char, and the string ends here
            cmdOut.valid <= 1'b1;
            cmdOut.kind <= gpib_msg_pkg::KIND_TRIG;
            cmdOut.data <= gpib_msg_pkg::TRIGGER_CHAR;
            strOpen_q <= 1'b0;
         end else if (clearPend_q && !measBusy) begin
            // flush then clear char at the head; held off while measuring
            cmdOut.valid <= 1'b1;
            cmdOut.kind <= gpib_msg_pkg::KIND_CLEAR;
            cmdOut.data <= gpib_msg_pkg::CLEAR_CHAR;
            bufFlush <= 1'b1;
            clearPend_q <= 1'b0;
         end
         // a new clear arriving as the old one leaves is kept
         if (cmdEv && (isDcl || isSdc)) clearPend_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial poll status; new string clears it but fresh events still land
   logic clearMask;
   assign clearMask = clearPend_q && !measBusy && !dataEv && !(cmdEv && isGet);
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pollBits_q <= '0;
         rqs_q <= 1'b0;
      end else begin
         if (dataEv && !strOpen_q) pollBits_q <= statusSet;
         else pollBits_q <= pollBits_q | statusSet;
         rqs_q <= |(pollBits_q & srqMask_q);
      end
   end

   // talk source and trigger execution
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         talkByte <= '0;
         measStart <= 1'b0;
      end else begin
         talkByte <= spoll_q ? pollByte : outBufByte;
         measStart <= execTrig;
      end
   end

   // status bundle; talk-only forces a permanent talker
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= '0;
      end else begin
         state.remote <= remote_q;
         state.lockout <= lockout_q;
         state.listener <= listener_q;
         state.talker <= talker_q || talkOnly_q;
         state.spoll <= spoll_q;
         state.talkOnly <= talkOnly_q;
         state.clearPending <= clearPend_q;
         state.rqs <= rqs_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register slave: one write and one read in flight
   logic awHave_q, wHave_q;
   logic [3:0] awAddr_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;

   function automatic logic known(input logic [3:0] a);
      known = (a == gpib_msg_pkg::CTRL_OFFSET) || (a == gpib_msg_pkg::MASK_OFFSET)
         || (a == gpib_msg_pkg::STATE_OFFSET) || (a == gpib_msg_pkg::POLL_OFFSET);
   endfunction

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= gpib_msg_pkg::RESP_OKAY;
         awHave_q <= 1'b0;
         wHave_q <= 1'b0;
         awAddr_q <= '0;
         wData_q <= '0;
         wStrb_q <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awAddr_q <= s_axi_awaddr[3:0];
            awHave_q <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
            wHave_q <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (awHave_q && wHave_q && !s_axi_bvalid) begin
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= known(awAddr_q) ? gpib_msg_pkg::RESP_OKAY
               : gpib_msg_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // writable registers; device clear wins over a software write to the mask
   logic doWrite;
   assign doWrite = awHave_q && wHave_q && !s_axi_bvalid && wStrb_q[0];
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         myAddr_q <= gpib_msg_pkg::ADDR_RESET;
         srqMask_q <= gpib_msg_pkg::MASK_RESET;
      end else begin
         if (doWrite && awAddr_q == gpib_msg_pkg::CTRL_OFFSET) myAddr_q <= wData_q[4:0];
         if (doWrite && awAddr_q == gpib_msg_pkg::MASK_OFFSET) srqMask_q <= wData_q[5:0];
         if (clearMask) srqMask_q <= gpib_msg_pkg::MASK_RESET;
      end
   end

   // read side answers one cycle after the address is taken
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= gpib_msg_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= known(s_axi_araddr[3:0]) ? gpib_msg_pkg::RESP_OKAY
            : gpib_msg_pkg::RESP_SLVERR;
         unique case (s_axi_araddr[3:0])
            gpib_msg_pkg::CTRL_OFFSET: s_axi_rdata <= {27'h0, myAddr_q};
            gpib_msg_pkg::MASK_OFFSET: s_axi_rdata <= {26'h0, srqMask_q};
            gpib_msg_pkg::STATE_OFFSET: s_axi_rdata <= {24'h0, state};
            gpib_msg_pkg::POLL_OFFSET: s_axi_rdata <= {24'h0, pollByte};
            default: s_axi_rdata <= 32'h0;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);

   chk_addr_not_queued: assert property (cmdEv && (isMla || isMta || isUnl || isUnt)
      |=> !(cmdOut.valid && cmdOut.kind == gpib_msg_pkg::KIND_DATA))
      else $error("address byte reached the buffer");
   chk_unlisten_drop: assert property (cmdEv && isUnl |=> !listener_q)
      else $error("listener kept after unlisten");
   chk_ifc_idle: assert property (ifcS |=> !listener_q && !talker_q && !spoll_q)
      else $error("interface not idle after clear");
   chk_listen_remote: assert property (cmdEv && isMla && renS |=> remote_q)
      else $error("no remote after own listen address");
   chk_ren_local: assert property (!renS |=> !remote_q && !lockout_q)
      else $error("remote or lockout kept without enable");
   chk_clear_waits: assert property (clearPend_q && measBusy
      |=> !(cmdOut.valid && cmdOut.kind == gpib_msg_pkg::KIND_CLEAR))
      else $error("clear issued during a measurement");
   chk_clear_flush: assert property (cmdOut.valid && cmdOut.kind == gpib_msg_pkg::KIND_CLEAR
      |-> bufFlush && cmdOut.data == gpib_msg_pkg::CLEAR_CHAR)
      else $error("clear char without flush");
   chk_lockout_button: assert property (lockout_q && btnEdge && renS
      && !(cmdEv && isGtl) |=> remote_q == $past(remote_q))
      else $error("panel button acted under lockout");
   chk_trigger_once: assert property (cmdEv && isGet |=> cmdOut.valid
      && cmdOut.kind == gpib_msg_pkg::KIND_TRIG ##1 !cmdOut.valid)
      else $error("trigger char not queued exactly once");
   chk_poll_talk: assert property (spoll_q |=> talkByte == $past(pollByte))
      else $error("poll byte not on the talk path");
   chk_foreign_talk: assert property (cmdEv && otherTalk |=> !talker_q)
      else $error("talker kept after foreign talk address");

endmodule // gpib_interface_message_handler
`default_nettype wire

// ==== gpib_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// behavioural bus controller on the far side of the instrument's bus pins
module gpib_ctrl_model (
   input wire logic sysClk,
   output logic [7:0] busData,
   output logic davPin,
   output logic atnPin,
   output logic ifcPin,
   output logic renPin
);
   // bus idle at time zero
   initial begin
      busData = 8'h00;
      davPin = 1'b0;
      atnPin = 1'b0;
      ifcPin = 1'b0;
      renPin = 1'b0;
   end
   //////////////////////////////////////////////////////////////////////////////
   // one byte: attention and data settle two cycles before the strobe rises
   task automatic put_byte(input logic atn, input logic [7:0] b);
      @(posedge sysClk);
      atnPin <= atn;
      busData <= b;
      repeat (2) @(posedge sysClk);
      davPin <= 1'b1;
      repeat (3) @(posedge sysClk);
      davPin <= 1'b0;
      repeat (3) @(posedge sysClk);
      busData <= ~b; // released lines must not keep showing the old byte
   endtask
   // interface clear held long enough for the pin synchronisers
   task automatic pulse_ifc();
      @(posedge sysClk);
      ifcPin <= 1'b1;
      repeat (4) @(posedge sysClk);
      ifcPin <= 1'b0;
      repeat (4) @(posedge sysClk);
   endtask
   task automatic set_ren(input logic v);
      @(posedge sysClk);
      renPin <= v;
      repeat (4) @(posedge sysClk);
   endtask
endmodule // gpib_ctrl_model
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [7:0] busData;
   logic davPin, atnPin, ifcPin, renPin;
   logic localBtn = 1'b0, talkOnlySw = 1'b0, measBusy = 1'b0, execTrig = 1'b0;
   logic [7:0] outBufByte = 8'h00;
   logic [5:0] statusSet = 6'h00;
   gpib_msg_pkg::cmd_out_type cmdOut;
   gpib_msg_pkg::state_type state;
   logic bufFlush, measStart;
   logic [7:0] talkByte;
   int failures = 0, checks = 0, seed = 32'h5002C6B4;
   logic [10:0] cmdQ[$];
   logic [4:0] myAddr;
   logic [31:0] rd;
   logic [1:0] resp;
   logic [7:0] b;

   always #12.5 sys_clk = ~sys_clk;

   gpib_interface_message_handler i_dut (.sys_clk, .arst_n, .s_axi_awvalid, .s_axi_awready,
      .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
      .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
      .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .busData, .davPin, .atnPin, .ifcPin, .renPin,
      .localBtn, .talkOnlySw, .measBusy, .execTrig, .outBufByte, .statusSet, .cmdOut, .bufFlush,
      .measStart, .talkByte, .state);
   gpib_ctrl_model i_ctrl (.sysClk(sys_clk), .busData, .davPin, .atnPin, .ifcPin, .renPin);

   // every queued char is logged with the flush flag seen in its cycle
   always @(posedge sys_clk) begin
      if (cmdOut.valid === 1'b1) cmdQ.push_back({bufFlush, cmdOut.kind, cmdOut.data});
   end
   //////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   // expected queue entry: flush flag, kind, char
   function automatic logic [10:0] ent(input logic f, input logic [1:0] k, input logic [7:0] c);
      return {f, k, c};
   endfunction
   task automatic expect_cmd(input string name, input logic [10:0] e);
      check(name, 32'(e), (cmdQ.size() > 0) ? 32'(cmdQ.pop_front()) : 32'h7FF);
   endtask
   task automatic expect_none();
      check("queued chars", 0, 32'(cmdQ.size()));
   endtask
   // write: address and data offered together, each dropped once taken
   task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
      bit done;
      done = 1'b0;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done) begin
         @(posedge sys_clk);
         if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask
   task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      bit done;
      done = 1'b0;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done) begin
         @(posedge sys_clk);
         if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask
   // one bus byte plus the two cycles the state port lags
   task automatic send(input logic atn, input logic [6:0] c);
      i_ctrl.put_byte(atn, {1'b0, c});
      repeat (2) @(posedge sys_clk);
   endtask
   //////////////////////////////////////////////////////////////////////////////
   // watchdog sized far above the few hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      tally_and_finish();
   end
   initial begin
      repeat (4) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      check("state after reset", 8'h00, state);
      axi_read(32'h0, rd, resp);
      check("own address reset", 32'h4, rd);
      axi_read(32'h2, rd, resp);
      check("unmapped resp", 32'h2, resp);
      myAddr = 5'($unsigned($random(seed)) % 31);
      axi_write(32'h0, {27'h0, myAddr}, resp);
      axi_read(32'h0, rd, resp);
      check("own address", {27'h0, myAddr}, rd);
      axi_write(32'h4, 32'($random(seed)) & 32'h3F, resp);
      i_ctrl.pulse_ifc();
      send(1'b1, gpib_msg_pkg::MSG_DEV_CLEAR);
      expect_cmd("clear char", ent(1'b1, 2'h2, gpib_msg_pkg::CLEAR_CHAR));
      axi_read(32'h4, rd, resp);
      check("mask after clear", 32'h0, rd);
      i_ctrl.set_ren(1'b1);
      send(1'b1, gpib_msg_pkg::LISTEN_GROUP | 7'(myAddr));
      check("listener", 1, state.listener);
      check("remote", 1, state.remote);
      expect_none();
      // random device data must pass straight through as data chars
      repeat (4) begin
         b = {1'b0, 7'($random(seed))};
         send(1'b0, b[6:0]);
         expect_cmd("data char", ent(1'b0, 2'h0, b));
      end
      send(1'b1, gpib_msg_pkg::MSG_TRIGGER);
      expect_cmd("trigger char", ent(1'b0, 2'h1, gpib_msg_pkg::TRIGGER_CHAR));
      execTrig <= 1'b1;
      @(posedge sys_clk);
      execTrig <= 1'b0;
      #1 check("meas start", 1, measStart);
      send(1'b1, gpib_msg_pkg::MSG_LOCKOUT);
      check("lockout", 1, state.lockout);
      localBtn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      localBtn <= 1'b0;
      repeat (3) @(posedge sys_clk);
      check("remote under lockout", 1, state.remote);
      send(1'b1, gpib_msg_pkg::TALK_GROUP | 7'(myAddr));
      check("talker", 1, state.talker);
      statusSet <= 6'h01;
      @(posedge sys_clk);
      statusSet <= 6'h00;
      send(1'b1, gpib_msg_pkg::MSG_POLL_ON);
      check("poll state", 1, state.spoll);
      check("poll byte", 8'h01, talkByte);
      // unmask the overrange bit: request bit must rise in state, poll register and talk path
      axi_write(32'h4, 32'h1, resp);
      check("mask write resp", 32'h0, resp);
      axi_read(32'h8, rd, resp);
      check("state register", 32'hF9, rd);
      axi_read(32'hC, rd, resp);
      check("poll register", 32'h41, rd);
      check("request bit", 1, state.rqs);
      check("poll byte with request", 8'h41, talkByte);
      send(1'b1, gpib_msg_pkg::MSG_POLL_OFF);
      outBufByte <= 8'($random(seed));
      repeat (3) @(posedge sys_clk);
      check("poll off", 0, state.spoll);
      check("buffer byte", outBufByte, talkByte);
      send(1'b1, gpib_msg_pkg::TALK_GROUP | 7'((myAddr + 5'd1) % 31));
      check("foreign talk", 0, state.talker);
      send(1'b1, gpib_msg_pkg::TALK_GROUP | 7'(myAddr));
      send(1'b1, gpib_msg_pkg::MSG_UNTALK);
      check("untalk", 0, state.talker);
      // clear held off by a running measurement
      measBusy <= 1'b1;
      send(1'b1, gpib_msg_pkg::MSG_DEV_CLEAR);
      check("clear pending", 1, state.clearPending);
      expect_none();
      measBusy <= 1'b0;
      repeat (4) @(posedge sys_clk);
      expect_cmd("late clear", ent(1'b1, 2'h2, gpib_msg_pkg::CLEAR_CHAR));
      check("rqs after clear", 0, state.rqs);
      send(1'b1, gpib_msg_pkg::MSG_SEL_CLEAR);
      expect_cmd("selected clear", ent(1'b1, 2'h2, gpib_msg_pkg::CLEAR_CHAR));
      send(1'b1, gpib_msg_pkg::MSG_UNLISTEN);
      check("unlisten", 0, state.listener);
      send(1'b1, gpib_msg_pkg::MSG_TRIGGER);
      send(1'b1, gpib_msg_pkg::MSG_SEL_CLEAR);
      send(1'b1, gpib_msg_pkg::MSG_GO_LOCAL);
      expect_none();
      check("remote kept", 1, state.remote);
      send(1'b1, gpib_msg_pkg::LISTEN_GROUP | 7'(myAddr));
      send(1'b1, gpib_msg_pkg::MSG_GO_LOCAL);
      check("go local", 0, state.remote);
      expect_none();
      send(1'b1, gpib_msg_pkg::LISTEN_GROUP | 7'(myAddr));
      i_ctrl.set_ren(1'b0);
      repeat (2) @(posedge sys_clk);
      check("ren low remote", 0, state.remote);
      check("ren low lockout", 0, state.lockout);
      talkOnlySw <= 1'b1;
      i_ctrl.pulse_ifc();
      check("talk only", 1, state.talkOnly);
      check("talk only talker", 1, state.talker);
      check("ifc listener", 0, state.listener);
      axi_read(32'h0, rd, resp);
      check("address kept", {27'h0, myAddr}, rd);
      talkOnlySw <= 1'b0;
      i_ctrl.pulse_ifc();
      check("talk only off", 0, state.talkOnly);
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
